/* File: core/spf_regs.svh */
`ifndef SPF_REGS_SVH
`define SPF_REGS_SVH

// Register addresses on the device register port.
`define SPF_ADDR_FUNC_EN 8'h20
`define SPF_ADDR_FUNC_SEL 8'h21
`define SPF_ADDR_DRV_UPPER 8'h22
`define SPF_ADDR_DRV_LOWER 8'h23
`define SPF_ADDR_OSC_CFG 8'h24
`define SPF_ADDR_GPO_STATE 8'h25
`define SPF_ADDR_DEB_CFG 8'h26
`define SPF_ADDR_LP_THRESH 8'h27

// Writable masks; reserved bits are dropped on write and read as zero.
`define SPF_FSEL_WMASK 4'he
`define SPF_OSC_WMASK 8'hd0
`define SPF_DEB_WMASK 8'hfe

// Field positions.
`define SPF_OSC_LOAD_BIT 7
`define SPF_OSC_XTAL_BIT 6
`define SPF_OSC_PP_BIT 4
`define SPF_DEB_TIME_HI 7
`define SPF_DEB_TIME_LO 4
`define SPF_DEB_EN_HI 3
`define SPF_DEB_EN_LO 1
`define SPF_UPPER_LO 8
`define SPF_UPPER_HI 11

// Pin groups and their idle values.
`define SPF_IN_ALL_HIGH 3'h7
`define SPF_SYNC_ALL_HIGH 4'hf
`define SPF_PINS_RELEASED 12'hfff
`define SPF_SYNC_CLK_IDX 3

// Timing: clock rate, debounce step and long-press step.
`define SPF_CLK_HZ 50000000
`define SPF_MS_PER_S 1000
`define SPF_DEB_STEP_MS 5
`define SPF_LP_STEP_MS 100

`endif

/* File: core/spf_pkg.sv */
package spf_pkg;

  // Configuration image, as loaded from nonvolatile memory.
  typedef struct packed {
    logic [3:0] func_en;
    logic [3:0] func_sel;
    logic [3:0] drv_upper;
    logic [7:0] drv_lower;
    logic [7:0] osc_cfg;
    logic [3:0] gpo;
    logic [7:0] deb_cfg;
    logic [7:0] lp_thresh;
  } spf_cfg_t;

  // State of one input filter.
  typedef struct packed {
    logic stable;
    logic [31:0] cnt;
  } spf_deb_st_t;

  // Press classifier states.
  typedef enum logic [1:0] {
    SPF_BTN_IDLE = 2'b01,
    SPF_BTN_HELD = 2'b10
  } spf_btn_t;

  // Whole state of the top module.
  typedef struct packed {
    spf_cfg_t cfg;
    logic loaded;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] acc;
    logic btn_n;
    logic rst_req_n;
    logic empd_n;
    spf_btn_t btn;
    logic [31:0] lp_cnt;
    logic long_p;
    logic short_p;
    logic [11:0] pin_out;
    logic [11:0] pin_oe_n;
    logic clk_out;
    logic clk_oe_n;
    logic xtal_on;
    logic crystal_load_internal;
    logic [7:0] rdata;
  } spf_top_st_t;

endpackage : spf_pkg

/* File: core/spf_debounce.sv */
`timescale 1ns/1ps
`include "spf_regs.svh"

module spf_debounce
  import spf_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic level_in,
  input wire logic filter_on_in,
  input wire logic [31:0] limit_in,
  output logic level_out
);

  spf_deb_st_t st_r;
  spf_deb_st_t st_nxt;

  ////////////////////////////////////////////////////////////////////////
  // A new level is taken once it has held for limit_in cycles in a row.
  always_comb begin
    st_nxt = st_r;
    if (srst_in) begin
      st_nxt.stable = 1'b1;
      st_nxt.cnt = '0;
    end else if (!filter_on_in) begin
      st_nxt.stable = level_in;
      st_nxt.cnt = '0;
    end else if (level_in == st_r.stable) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt + 32'h1 >= limit_in) begin
      st_nxt.stable = level_in;
      st_nxt.cnt = '0;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end

  // State register.
  always_ff @(posedge clk_in) begin
    st_r <= st_nxt;
  end

  assign level_out = st_r.stable;

endmodule : spf_debounce

/* File: core/spf_pin_config.sv */
`timescale 1ns/1ps
`include "spf_regs.svh"

// Overview of operation
// - Pin 12 is general output at select 0, power button input at 1.
// - Pin 11 is general output at select 0, reset request input at 1.
// - Pin 10 is general output at select 0, emergency power-down input at 1.
// - Pin 9 has only general output; its select bit always reads 0.
// - Pins 12 to 9 drive open drain at mode 0, push-pull at 1.
// - Pins 8 to 1 drive open drain at mode 0, push-pull at 1.
// - Crystal load is external at bit 7 clear, internal when set.
// - Crystal driver runs only while oscillator bit 6 is set.
// - Slow clock pin is open drain at bit 4 clear, push-pull when set.
// - General output bit drives pin only while power and sleep bits clear.
// - General output only when function enabled and output function selected.
// - Output, debounce and long-press registers writable unless control group protected.
// - Debounce time equals five times N plus one milliseconds.
// - Each input filter acts only while its enable bit is set.
// - Press lasting at least (N+1) times 100 ms is long, else short.
// - Select, drive and oscillator registers load from memory, then read-only.
// - Pin function works only with its enable bit set, else sequencing.
// - Nonzero sequence fields lock the pin to sequencing.
module spf_pin_config
  import spf_pkg::*;
#(
  parameter int DEB_STEP_CYC = `SPF_CLK_HZ / `SPF_MS_PER_S * `SPF_DEB_STEP_MS,
  parameter int LP_STEP_CYC = `SPF_CLK_HZ / `SPF_MS_PER_S * `SPF_LP_STEP_MS
) (
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic CTL_PROTECT_IN,
  input wire logic NVM_LOAD_IN,
  input wire spf_cfg_t NVM_DATA_IN,
  input wire logic [11:0] SEQ_LEVEL_IN,
  input wire logic [3:0] SEQ_LOCK_IN,
  input wire logic [3:0] PWR_SEQ_IN,
  input wire logic [3:0] SLP_SEQ_IN,
  input wire logic [2:0] PIN_IN,
  input wire logic SLOW_CLK_IN,
  output logic [7:0] REG_RDATA_OUT,
  output logic [11:0] PIN_OUT,
  output logic [11:0] PIN_OE_N_OUT,
  output logic SLOW_CLK_OUT,
  output logic SLOW_CLK_OE_N_OUT,
  output logic XTAL_DRIVER_ON_OUT,
  output logic CRYSTAL_LOAD_INTERNAL_INTERNAL_OUT,
  output logic POWER_BUTTON_N_OUT,
  output logic RESET_REQUEST_N_OUT,
  output logic EMERGENCY_PD_N_OUT,
  output logic LONG_PRESS_OUT,
  output logic SHORT_PRESS_OUT
);

  ////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Cycle count of a step time scaled by a field value plus one.
  function automatic logic [31:0] spf_scale(input int step, input logic [7:0] n);
    logic [31:0] prod;
    prod = 32'(step) * (32'(n) + 32'h1);
    return prod;
  endfunction : spf_scale

  // Pin drive: bit 1 is the data, bit 0 the active-low enable.
  function automatic logic [1:0] spf_drive(input logic level, input logic pp);
    logic [1:0] d;
    if (pp) begin
      d = {level, 1'b0};
    end else begin
      d = {1'b0, level};
    end
    return d;
  endfunction : spf_drive

  ////////////////////////////////////////////////////////////////////////
  // State and filtered inputs.

  spf_top_st_t st_r;
  spf_top_st_t st_nxt;
  logic [2:0] filt_lvl;
  logic [31:0] deb_limit;
  logic [31:0] lp_limit;
  logic [3:0] fn_active;
  logic [3:0] fsel_eff;
  logic [3:0] in_mode;
  logic [3:0] gpo_mode;
  logic [2:0] deb_on;

  // Limits from the debounce and long-press fields.
  // debounce scaling
  assign deb_limit = spf_scale(DEB_STEP_CYC,
    {4'h0, st_r.cfg.deb_cfg[`SPF_DEB_TIME_HI:`SPF_DEB_TIME_LO]});
  assign lp_limit = spf_scale(LP_STEP_CYC, st_r.cfg.lp_thresh);
  assign deb_on = st_r.cfg.deb_cfg[`SPF_DEB_EN_HI:`SPF_DEB_EN_LO];

  // Function decode for pins 12 to 9; index 0 is pin 9.
  // function enable
  assign fn_active = st_r.cfg.func_en & ~SEQ_LOCK_IN;
  assign fsel_eff = {st_r.cfg.func_sel[3:1], 1'b0};
  assign in_mode = fn_active & fsel_eff;
  assign gpo_mode = fn_active & ~fsel_eff;

  ////////////////////////////////////////////////////////////////////////
  // Input filters for pins 10, 11 and 12, fed from the synchronisers.
  for (genvar g = 0; g < 3; g++) begin : g_deb
    spf_debounce u_deb (
      .clk_in(CLOCK_IN),
      .srst_in(SRST_IN),
      .level_in(st_r.acc[g]),
      .filter_on_in(deb_on[g]),
      .limit_in(deb_limit),
      .level_out(filt_lvl[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    logic [1:0] drv;
    logic lvl;
    logic wr_ok;
    logic btn_lvl;
    drv = 2'b00;
    lvl = 1'b0;
    wr_ok = 1'b0;
    btn_lvl = 1'b1;
    st_nxt = st_r;

    // Synchronisers: three stages, accepted when the last two agree.
    st_nxt.s1 = {SLOW_CLK_IN, PIN_IN};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < 4; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.acc[i] = st_r.s3[i];
      end
    end

    // Configuration load from nonvolatile memory wins over a write.
    if (NVM_LOAD_IN) begin
      st_nxt.cfg = NVM_DATA_IN;
      st_nxt.cfg.func_sel = NVM_DATA_IN.func_sel & `SPF_FSEL_WMASK;
      st_nxt.cfg.osc_cfg = NVM_DATA_IN.osc_cfg & `SPF_OSC_WMASK;
      st_nxt.cfg.deb_cfg = NVM_DATA_IN.deb_cfg & `SPF_DEB_WMASK;
      st_nxt.loaded = 1'b1;
    end else if (REG_WR_IN) begin
      wr_ok = !CTL_PROTECT_IN;
      case (REG_ADDR_IN)
        `SPF_ADDR_FUNC_EN: begin
          if (!st_r.loaded) begin
            st_nxt.cfg.func_en = REG_WDATA_IN[3:0];
          end
        end
        `SPF_ADDR_FUNC_SEL: begin
          if (!st_r.loaded) begin
            st_nxt.cfg.func_sel = REG_WDATA_IN[3:0] & `SPF_FSEL_WMASK;
          end
        end
        `SPF_ADDR_DRV_UPPER: begin
          if (!st_r.loaded) begin
            st_nxt.cfg.drv_upper = REG_WDATA_IN[3:0];
          end
        end
        `SPF_ADDR_DRV_LOWER: begin
          if (!st_r.loaded) begin
            st_nxt.cfg.drv_lower = REG_WDATA_IN;
          end
        end
        `SPF_ADDR_OSC_CFG: begin
          if (!st_r.loaded) begin
            st_nxt.cfg.osc_cfg = REG_WDATA_IN & `SPF_OSC_WMASK;
          end
        end
        `SPF_ADDR_GPO_STATE: begin
          if (wr_ok) begin
            st_nxt.cfg.gpo = REG_WDATA_IN[3:0];
          end
        end
        `SPF_ADDR_DEB_CFG: begin
          if (wr_ok) begin
            st_nxt.cfg.deb_cfg = REG_WDATA_IN & `SPF_DEB_WMASK;
          end
        end
        `SPF_ADDR_LP_THRESH: begin
          if (wr_ok) begin
            st_nxt.cfg.lp_thresh = REG_WDATA_IN;
          end
        end
        default: begin
          st_nxt.cfg = st_r.cfg;
        end
      endcase
    end

    // Register read port, one cycle behind the address.
    // reserved read zero
    case (REG_ADDR_IN)
      `SPF_ADDR_FUNC_EN: st_nxt.rdata = {4'h0, st_r.cfg.func_en};
      `SPF_ADDR_FUNC_SEL: st_nxt.rdata = {4'h0, fsel_eff};
      `SPF_ADDR_DRV_UPPER: st_nxt.rdata = {4'h0, st_r.cfg.drv_upper};
      `SPF_ADDR_DRV_LOWER: st_nxt.rdata = st_r.cfg.drv_lower;
      `SPF_ADDR_OSC_CFG: st_nxt.rdata = st_r.cfg.osc_cfg;
      `SPF_ADDR_GPO_STATE: st_nxt.rdata = {4'h0, st_r.cfg.gpo};
      `SPF_ADDR_DEB_CFG: st_nxt.rdata = st_r.cfg.deb_cfg;
      `SPF_ADDR_LP_THRESH: st_nxt.rdata = st_r.cfg.lp_thresh;
      default: st_nxt.rdata = 8'h00;
    endcase

    // Lower sequencing pins 8 to 1 always follow the sequencer.
    for (int i = 0; i < `SPF_UPPER_LO; i++) begin
      drv = spf_drive(SEQ_LEVEL_IN[i], st_r.cfg.drv_lower[i]);
      st_nxt.pin_out[i] = drv[1];
      st_nxt.pin_oe_n[i] = drv[0];
    end

    // Upper pins 12 to 9: input, general output or sequencing.
    for (int j = 0; j < 4; j++) begin
      lvl = SEQ_LEVEL_IN[`SPF_UPPER_LO + j];
      if (gpo_mode[j] && !PWR_SEQ_IN[j] && !SLP_SEQ_IN[j]) begin
        lvl = st_r.cfg.gpo[j];
      end
      drv = spf_drive(lvl, st_r.cfg.drv_upper[j]);
      if (in_mode[j]) begin
        drv = 2'b01;
      end
      st_nxt.pin_out[`SPF_UPPER_LO + j] = drv[1];
      st_nxt.pin_oe_n[`SPF_UPPER_LO + j] = drv[0];
    end

    // Input functions; an unused input reads as released.
    // power button
    st_nxt.btn_n = in_mode[3] ? filt_lvl[2] : 1'b1;
    st_nxt.rst_req_n = in_mode[2] ? filt_lvl[1] : 1'b1;
    st_nxt.empd_n = in_mode[1] ? filt_lvl[0] : 1'b1;
    btn_lvl = st_nxt.btn_n;

    // Press classifier: count low cycles, judge on release.
    st_nxt.long_p = 1'b0;
    st_nxt.short_p = 1'b0;
    case (st_r.btn)
      SPF_BTN_IDLE: begin
        st_nxt.lp_cnt = '0;
        if (!btn_lvl) begin
          st_nxt.btn = SPF_BTN_HELD;
          st_nxt.lp_cnt = 32'h1;
        end
      end
      SPF_BTN_HELD: begin
        if (btn_lvl) begin
          st_nxt.long_p = (st_r.lp_cnt >= lp_limit);
          st_nxt.short_p = (st_r.lp_cnt < lp_limit);
          st_nxt.btn = SPF_BTN_IDLE;
          st_nxt.lp_cnt = '0;
        end else if (st_r.lp_cnt < lp_limit) begin
          st_nxt.lp_cnt = st_r.lp_cnt + 32'h1;
        end
      end
      default: begin
        st_nxt.btn = SPF_BTN_IDLE;
        st_nxt.lp_cnt = '0;
      end
    endcase

    // Oscillator controls and the slow clock output pin.
    // crystal load
    st_nxt.crystal_load_internal = st_r.cfg.osc_cfg[`SPF_OSC_LOAD_BIT];
    st_nxt.xtal_on = st_r.cfg.osc_cfg[`SPF_OSC_XTAL_BIT];
    drv = spf_drive(st_r.acc[`SPF_SYNC_CLK_IDX], st_r.cfg.osc_cfg[`SPF_OSC_PP_BIT]);
    st_nxt.clk_out = drv[1];
    st_nxt.clk_oe_n = drv[0];

    // Synchronous reset: pins released, inputs idle high.
    if (SRST_IN) begin
      st_nxt = '0;
      st_nxt.s1 = `SPF_SYNC_ALL_HIGH;
      st_nxt.s2 = `SPF_SYNC_ALL_HIGH;
      st_nxt.s3 = `SPF_SYNC_ALL_HIGH;
      st_nxt.acc = `SPF_SYNC_ALL_HIGH;
      st_nxt.btn_n = 1'b1;
      st_nxt.rst_req_n = 1'b1;
      st_nxt.empd_n = 1'b1;
      st_nxt.btn = SPF_BTN_IDLE;
      st_nxt.pin_oe_n = `SPF_PINS_RELEASED;
      st_nxt.clk_oe_n = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge CLOCK_IN) begin
    st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state register.
  assign REG_RDATA_OUT = st_r.rdata;
  assign PIN_OUT = st_r.pin_out;
  assign PIN_OE_N_OUT = st_r.pin_oe_n;
  assign SLOW_CLK_OUT = st_r.clk_out;
  assign SLOW_CLK_OE_N_OUT = st_r.clk_oe_n;
  assign XTAL_DRIVER_ON_OUT = st_r.xtal_on;
  assign CRYSTAL_LOAD_INTERNAL_INTERNAL_OUT = st_r.crystal_load_internal;
  assign POWER_BUTTON_N_OUT = st_r.btn_n;
  assign RESET_REQUEST_N_OUT = st_r.rst_req_n;
  assign EMERGENCY_PD_N_OUT = st_r.empd_n;
  assign LONG_PRESS_OUT = st_r.long_p;
  assign SHORT_PRESS_OUT = st_r.short_p;

endmodule : spf_pin_config

/* File: sim/spf_checker.sv */
`timescale 1ns/1ps
module spf_checker
  import spf_pkg::*;
#(
  parameter int DEB_STEP_CYC = 4,
  parameter int LP_STEP_CYC = 10
) (
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic CTL_PROTECT_IN,
  input wire logic NVM_LOAD_IN,
  input wire spf_cfg_t NVM_DATA_IN,
  input wire logic [11:0] SEQ_LEVEL_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic [11:0] PIN_OUT,
  input wire logic [11:0] PIN_OE_N_OUT,
  input wire logic XTAL_DRIVER_ON_OUT,
  input wire logic CRYSTAL_LOAD_INTERNAL_INTERNAL_OUT,
  input wire logic POWER_BUTTON_N_OUT,
  input wire logic LONG_PRESS_OUT,
  input wire logic SHORT_PRESS_OUT
);
  // Slices of the inputs that the properties look back on.
  logic [1:0] osc_hi;
  logic [7:0] seq_lo;
  assign osc_hi = NVM_DATA_IN.osc_cfg[7:6];
  assign seq_lo = SEQ_LEVEL_IN[7:0];
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);
  ////////////////////////////////////////
  // A single load pulse, a register write with a given protect level and a plain read cycle.
  sequence s_load;
    NVM_LOAD_IN ##1 !NVM_LOAD_IN;
  endsequence
  sequence s_rd(logic [7:0] a);
    REG_ADDR_IN == a && !REG_WR_IN && !NVM_LOAD_IN;
  endsequence
  sequence s_wr(logic [7:0] a, logic p);
    REG_WR_IN && !NVM_LOAD_IN && CTL_PROTECT_IN == p && REG_ADDR_IN == a;
  endsequence
  a_xtal_from_load: assert property (s_load |=>
    {CRYSTAL_LOAD_INTERNAL_INTERNAL_OUT, XTAL_DRIVER_ON_OUT} == $past(osc_hi, 2))
    else $error("crystal outputs differ from loaded image");
  a_fsel_bit_zero: assert property (s_rd(8'h21) |=> REG_RDATA_OUT[0] == 1'b0)
    else $error("pin 9 select bit reads one");
  a_osc_resv_zero: assert property (
    s_rd(8'h24) |=> (REG_RDATA_OUT & 8'h2f) == 8'h00)
    else $error("oscillator reserved bits read nonzero");
  a_unmapped_zero: assert property (
    !(REG_ADDR_IN inside {[8'h20:8'h27]}) |=> REG_RDATA_OUT == 8'h00)
    else $error("unmapped address reads nonzero");
  a_gpo_write_seen: assert property (s_wr(8'h25, 1'b0) ##1 s_rd(8'h25)
    |=> REG_RDATA_OUT == {4'h0, $past(REG_WDATA_IN[3:0], 2)})
    else $error("output state write not seen");
  a_protect_holds: assert property (s_wr(8'h27, 1'b1) ##1 s_rd(8'h27)
    |=> $stable(REG_RDATA_OUT))
    else $error("protected write changed threshold");
  a_press_after_release: assert property (
    (LONG_PRESS_OUT || SHORT_PRESS_OUT) |->
    POWER_BUTTON_N_OUT && !$past(POWER_BUTTON_N_OUT))
    else $error("press pulse not tied to release");
  a_press_one_kind: assert property (!(LONG_PRESS_OUT && SHORT_PRESS_OUT))
    else $error("long and short press together");
  a_lower_level: assert property (!SRST_IN |=>
    (PIN_OUT[7:0] | PIN_OE_N_OUT[7:0]) == $past(seq_lo))
    else $error("lower pin level differs from sequencer");
  a_no_high_release: assert property ((PIN_OUT & PIN_OE_N_OUT) == 12'h000)
    else $error("pin data high while released");
endmodule : spf_checker

bind spf_pin_config spf_checker #(
  .DEB_STEP_CYC(DEB_STEP_CYC),
  .LP_STEP_CYC(LP_STEP_CYC)
) spf_checker_i (
  .CLOCK_IN(CLOCK_IN),
  .SRST_IN(SRST_IN),
  .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN),
  .REG_WR_IN(REG_WR_IN),
  .CTL_PROTECT_IN(CTL_PROTECT_IN),
  .NVM_LOAD_IN(NVM_LOAD_IN),
  .NVM_DATA_IN(NVM_DATA_IN),
  .SEQ_LEVEL_IN(SEQ_LEVEL_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT),
  .PIN_OUT(PIN_OUT),
  .PIN_OE_N_OUT(PIN_OE_N_OUT),
  .XTAL_DRIVER_ON_OUT(XTAL_DRIVER_ON_OUT),
  .CRYSTAL_LOAD_INTERNAL_INTERNAL_OUT(CRYSTAL_LOAD_INTERNAL_INTERNAL_OUT),
  .POWER_BUTTON_N_OUT(POWER_BUTTON_N_OUT),
  .LONG_PRESS_OUT(LONG_PRESS_OUT),
  .SHORT_PRESS_OUT(SHORT_PRESS_OUT)
);

/* File: sim/spf_partner.sv */
`timescale 1ns/1ps
module spf_partner (
  input wire logic [11:0] pin_out_in,
  input wire logic [11:0] pin_oe_n_in,
  input wire logic [2:0] press_in,
  output logic [2:0] pin_n_out
);
  // Pins 12 to 10: a closed contact pulls low, a released pin rises
  // on its pull-up, a driven pin shows the driven level.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_n_out[i] = !press_in[i] && (pin_oe_n_in[9 + i] || pin_out_in[9 + i]);
    end
  end
endmodule : spf_partner

/* File: sim/spf_pin_config_test.sv */
`timescale 1ns/1ps
module spf_pin_config_test;
  import spf_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wr = 1'b0;
  logic prot = 1'b0;
  logic load = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [11:0] seq_lvl = 12'h000;
  logic [3:0] lock = 4'h0;
  logic [3:0] pwr = 4'h0;
  logic [3:0] slp = 4'h0;
  logic [2:0] press = 3'h0;
  logic sclk = 1'b1;
  logic sclk_o, sclk_oe_n;
  spf_cfg_t nvm = '0;
  logic [3:0] en, fsel, dup, gpo;
  logic [7:0] dlo, rdata;
  logic [2:0] pin_n;
  logic [11:0] pin_o, pin_oe_n;
  logic xtal_on, xtal_ld, btn_n, rst_n, empd_n, lp_o, sp_o;
  int fails = 0;
  int samples_checked = 0;

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  spf_pin_config #(.DEB_STEP_CYC(4), .LP_STEP_CYC(10)) spf_pin_config_i (
    .CLOCK_IN(clk), .SRST_IN(srst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .CTL_PROTECT_IN(prot), .NVM_LOAD_IN(load), .NVM_DATA_IN(nvm),
    .SEQ_LEVEL_IN(seq_lvl), .SEQ_LOCK_IN(lock), .PWR_SEQ_IN(pwr), .SLP_SEQ_IN(slp),
    .PIN_IN(pin_n), .SLOW_CLK_IN(sclk), .REG_RDATA_OUT(rdata), .PIN_OUT(pin_o),
    .PIN_OE_N_OUT(pin_oe_n), .SLOW_CLK_OUT(sclk_o), .SLOW_CLK_OE_N_OUT(sclk_oe_n),
    .XTAL_DRIVER_ON_OUT(xtal_on), .CRYSTAL_LOAD_INTERNAL_INTERNAL_OUT(xtal_ld),
    .POWER_BUTTON_N_OUT(btn_n), .RESET_REQUEST_N_OUT(rst_n),
    .EMERGENCY_PD_N_OUT(empd_n), .LONG_PRESS_OUT(lp_o), .SHORT_PRESS_OUT(sp_o));

  spf_partner spf_partner_i (.pin_out_in(pin_o), .pin_oe_n_in(pin_oe_n),
    .press_in(press), .pin_n_out(pin_n));

  ////////////////////////////////////////
  // Comparisons, one task for register bytes and one for pin groups.
  task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk_reg
  task automatic chk_pin(input string what, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk_pin

  // Register port cycles, entered and left at a falling edge.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    @(negedge clk);
    chk_reg($sformatf("register %h", a), exp, rdata);
  endtask : rd_reg

  // Loads an image and checks the crystal controls that follow it.
  task automatic nvm_load(input logic [3:0] e, s, u, input logic [7:0] l, o);
    sclk = ~sclk;
    nvm.func_en = e;
    nvm.func_sel = s;
    nvm.drv_upper = u;
    nvm.drv_lower = l;
    nvm.osc_cfg = o;
    nvm.lp_thresh = 8'h01;
    en = e;
    fsel = s & 4'he;
    dup = u;
    dlo = l;
    // Lets the new slow clock level pass the synchroniser first.
    repeat (4) @(negedge clk);
    load = 1'b1;
    @(negedge clk);
    load = 1'b0;
    @(negedge clk);
    chk_pin("crystal outputs", {10'h0, o[7:6]}, {10'h0, xtal_ld, xtal_on});
    chk_pin("slow clock pin", {10'h0, sclk & o[4], sclk & ~o[4]}, {10'h0, sclk_o, sclk_oe_n});
  endtask : nvm_load

  // Expected enables and data of all twelve pins.
  function automatic logic [23:0] exp_pins();
    logic [11:0] o, e;
    logic act, lv;
    o = {4'h0, seq_lvl[7:0] & dlo};
    e = {4'h0, seq_lvl[7:0] & ~dlo};
    for (int j = 0; j < 4; j++) begin
      act = en[j] & ~lock[j];
      lv = (act & ~fsel[j] & ~pwr[j] & ~slp[j]) ? gpo[j] : seq_lvl[8 + j];
      o[8 + j] = (act & fsel[j]) ? 1'b0 : lv & dup[j];
      e[8 + j] = (act & fsel[j]) ? 1'b1 : lv & ~dup[j];
    end
    return {e, o};
  endfunction : exp_pins

  // Sweeps lock, sequence bits and levels against the current image.
  task automatic pin_sweep();
    logic [23:0] x;
    for (int k = 0; k < 4; k++) begin
      lock = (k == 1) ? 4'h3 : 4'h0;
      pwr = (k == 2) ? 4'h5 : 4'h0;
      slp = (k == 3) ? 4'ha : 4'h0;
      seq_lvl = k[0] ? 12'ha3c : 12'h5c3;
      gpo = 4'h9 ^ 4'(k);
      wr_reg(8'h25, {4'h0, gpo});
      @(negedge clk);
      x = exp_pins();
      chk_pin("pin data", x[11:0], pin_o);
      chk_pin("pin enables", x[23:12], pin_oe_n);
    end
  endtask : pin_sweep

  // Holds the button for n cycles and checks the kind of press reported.
  task automatic press_btn(input int n, input logic [1:0] exp);
    int c;
    c = 0;
    press[2] = 1'b1;
    repeat (n) @(negedge clk);
    chk_pin("button level", 12'h000, {11'h0, btn_n});
    press[2] = 1'b0;
    while ((lp_o | sp_o) !== 1'b1 && c < 20) begin
      @(negedge clk);
      c++;
    end
    chk_pin("press kind", {10'h0, exp}, {10'h0, lp_o, sp_o});
  endtask : press_btn

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // Cuts a hang short well past the expected run length.
  initial begin
    #400000;
    fails++;
    final_report();
  end

  ////////////////////////////////////////
  // Main sequence.
  initial begin
    int c;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    for (int a = 32; a < 40; a++) rd_reg(8'(a), 8'h00);
    wr_reg(8'h24, 8'hff);
    rd_reg(8'h24, 8'hd0);
    wr_reg(8'h21, 8'hff);
    rd_reg(8'h21, 8'h0e);
    nvm_load(4'hf, 4'h0, 4'ha, 8'h5a, 8'h40);
    wr_reg(8'h21, 8'hff);
    rd_reg(8'h21, 8'h00);
    wr_reg(8'h22, 8'h0f);
    rd_reg(8'h22, 8'h0a);
    rd_reg(8'h23, 8'h5a);
    wr_reg(8'h30, 8'hff);
    rd_reg(8'h30, 8'h00);
    prot = 1'b1;
    wr_reg(8'h27, 8'h77);
    rd_reg(8'h27, 8'h01);
    prot = 1'b0;
    pin_sweep();
    nvm_load(4'he, 4'hf, 4'h5, 8'ha5, 8'hff);
    pin_sweep();
    wr_reg(8'h26, 8'h15);
    rd_reg(8'h26, 8'h14);
    press = 3'b011;
    repeat (7) @(negedge clk);
    chk_pin("filtered inputs", 12'h002, {10'h0, rst_n, empd_n});
    c = 7;
    while (rst_n !== 1'b0 && c < 30) begin
      @(negedge clk);
      c++;
    end
    chk_reg("filter delay in range", 8'h01, 8'(c >= 11 && c <= 16));
    press = 3'b000;
    repeat (20) @(negedge clk);
    press = 3'b010;
    repeat (5) @(negedge clk);
    press = 3'b000;
    c = 0;
    repeat (20) begin
      @(negedge clk);
      if (rst_n !== 1'b1) c++;
    end
    chk_reg("short glitch cycles", 8'h00, 8'(c));
    press_btn(8, 2'b01);
    press_btn(40, 2'b10);
    wr_reg(8'h27, 8'h03);
    press_btn(30, 2'b01);
    final_report();
  end
endmodule : spf_pin_config_test
